// ==== src/gpib_device_message_handler.sv ====
/*
 * device-side message handler: addressing, remote/local/lockout state,
 * serial poll, command string buffering and record output framing.
 * assumes acceptor and source handshakes (DAV/NRFD/NDAC) live outside on clk,
 * deliver each received byte with its ATN state, and take bytes on tx_ready.
 */
`timescale 1ns/1ps
module gpib_device_message_handler
	import msg_pkg::*;
#(
	parameter int unsigned KEY_HOLD = KEY_HOLD_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              ren_n,          // bus pin, low = remote enable
	input  wire logic              ifc_n,          // bus pin, low = interface clear
	input  wire logic [ADDR_W-1:0] addr_sw,        // switch pins, bit 4 is first switch
	input  wire logic              local_key,      // panel pin
	input  wire logic              remote_key,     // panel pin
	input  wire logic              rx_valid,       // byte accepted by handshake
	input  wire logic [7:0]        rx_data,
	input  wire logic              rx_atn,         // ATN was asserted with byte
	output logic                   rx_busy,        // hold off further bytes
	output logic                   tx_valid,
	output logic [7:0]             tx_data,
	output logic                   tx_eoi,
	input  wire logic              tx_ready,       // source takes byte this cycle
	output logic                   rec_req,        // pulse: record wanted
	output logic [7:0]             out_request,    // selects record
	output logic                   rec_ready,
	input  wire logic              rec_valid,
	input  wire logic [7:0]        rec_data,
	input  wire logic              rec_last,
	output logic                   exec_valid,     // pulse per executed char
	output logic [7:0]             exec_char,
	output logic                   exec_last,
	output logic                   dev_clear,      // pulse: back to power-up
	input  wire logic              service_req,
	input  wire logic [7:0]        status_in,
	output logic                   srq_o,          // open-drain pin value
	output logic                   srq_oe,
	output logic                   remote,
	output logic                   lockout,
	output logic                   listener,
	output logic                   talker,
	output logic                   show_addr,
	output logic [ADDR_W-1:0]      disp_addr
);

	// ==================================================================
	// synchronised pins
	logic [3:0]        pins_s;                  // ren, ifc, local, remote keys
	logic [ADDR_W-1:0] sw_s;                    // address switches
	logic              hold_s;                  // remote key held long

	sync2 #(.W(4)) u_pins (
		.clk     (clk),
		.reset_n (reset_n),
		.din     ({~ren_n, ~ifc_n, local_key, remote_key}),
		.dout    (pins_s)
	);

	sync2 #(.W(ADDR_W)) u_sw (
		.clk     (clk),
		.reset_n (reset_n),
		.din     (addr_sw),
		.dout    (sw_s)
	);

	hold_timer #(.CYCLES(KEY_HOLD)) u_hold (
		.clk     (clk),
		.reset_n (reset_n),
		.key     (pins_s[0]),
		.held    (hold_s)
	);

	wire ren_s  = pins_s[3];
	wire ifc_s  = pins_s[2];
	wire lkey_s = pins_s[1];
	wire rkey_s = pins_s[0];

	// ==================================================================
	// state registers
	logic [1:0]          boot_r;                 // startup cycles
	logic [ADDR_W-1:0]   my_addr_r;              // address caught once
	logic                lkey_d_r, rkey_d_r;     // key edge memory
	logic                remote_r, lockout_r;
	logic                listener_r, talker_r, spoll_r;
	logic                clear_r;
	phase_e              phase_r;
	logic [7:0]          buf_r [BUF_DEPTH];      // command characters
	logic [BUF_AW:0]     wr_r, rd_r;             // fill and replay index
	logic                got_cr_r;               // first terminator seen
	logic [7:0]          prev_r;                 // previous executed char
	logic [7:0]          req_r;                  // last output request
	logic                sent_r;                 // talk turn already served
	logic                tx_valid_r, tx_eoi_r, rec_ready_r, rec_req_r, last_r;
	logic [7:0]          tx_data_r;
	logic                exec_valid_r, exec_last_r;
	logic [7:0]          exec_char_r;
	logic                srq_oe_r, srq_o_r, show_r;

	// ==================================================================
	// message decode
	wire is_cmd    = rx_valid & rx_atn;
	wire is_data   = rx_valid & ~rx_atn;
	wire my_listen = is_cmd & (rx_data == addr_char(GRP_LISTEN, my_addr_r));
	wire my_talk   = is_cmd & (rx_data == addr_char(GRP_TALK, my_addr_r));
	wire oth_talk  = is_cmd & (rx_data[6:5] == GRP_TALK) & ~my_talk & (rx_data != CMD_UNT);
	wire cmd_unl   = is_cmd & (rx_data == CMD_UNL);
	wire cmd_unt   = is_cmd & (rx_data == CMD_UNT);
	wire cmd_llo   = is_cmd & (rx_data == CMD_LLO);
	wire cmd_dcl   = is_cmd & (rx_data == CMD_DCL);
	wire cmd_sdc   = is_cmd & listener_r & (rx_data == CMD_SDC);
	wire cmd_gtl   = is_cmd & listener_r & (rx_data == CMD_GTL);
	wire cmd_spe   = is_cmd & listener_r & (rx_data == CMD_SPE);
	wire cmd_spd   = is_cmd & (rx_data == CMD_SPD);
	wire do_clear  = cmd_dcl | cmd_sdc;

	// executed character effects
	wire [7:0] cur_ch  = buf_r[rd_r[BUF_AW-1:0]];
	wire       in_exec = (phase_r == ph_exec) & (rd_r != wr_r);
	wire       ex_m0   = in_exec & (prev_r == CHAR_MODE) & (cur_ch == CHAR_0);
	wire       ex_m1   = in_exec & (prev_r == CHAR_MODE) & (cur_ch == CHAR_1);
	wire       ex_m2   = in_exec & (prev_r == CHAR_MODE) & (cur_ch == CHAR_2);
	wire       ex_req  = in_exec & (prev_r == CHAR_REQ);

	// panel key edges
	wire lkey_hit = lkey_s & ~lkey_d_r & ~lockout_r;
	wire rkey_hit = rkey_s & ~rkey_d_r;

	// data may enter only as a remote listener with the sequencer free
	wire take_data = is_data & listener_r & remote_r & (phase_r == ph_idle);
	wire tx_taken  = tx_valid_r & tx_ready;
	wire [7:0] status_byte = {status_in[7], service_req, status_in[STB_RQS-1:0]};

	// ==================================================================
	// address capture at power-up only; switch moves later are ignored
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_r    <= '0;
			my_addr_r <= '0;
		end else if (boot_r != BOOT_LAST) begin
			boot_r <= boot_r + 1'b1;
			if (boot_r == BOOT_LAST - 2'h1)
				my_addr_r <= sw_s;
		end
	end

	// ==================================================================
	// addressing; IFC wins over any command in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			listener_r <= 1'b0;
			talker_r   <= 1'b0;
			spoll_r    <= 1'b0;
		end else if (ifc_s) begin
			listener_r <= 1'b0;
			talker_r   <= 1'b0;
			spoll_r    <= 1'b0;
		end else begin
			if (my_listen)
				listener_r <= 1'b1;
			else if (cmd_unl | my_talk)
				listener_r <= 1'b0;
			if (my_talk)
				talker_r <= 1'b1;
			else if (cmd_unt | oth_talk | my_listen)
				talker_r <= 1'b0;
			if (cmd_spe)
				spoll_r <= 1'b1;
			else if (cmd_spd)
				spoll_r <= 1'b0;
		end
	end

	// ==================================================================
	// remote / local / lockout; releasing REN drops both
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			remote_r  <= 1'b0;
			lockout_r <= 1'b0;
			lkey_d_r  <= 1'b0;
			rkey_d_r  <= 1'b0;
		end else begin
			lkey_d_r <= lkey_s;
			rkey_d_r <= rkey_s;
			if (!ren_s)
				remote_r <= 1'b0;
			else if (my_listen | ex_m1 | ex_m2 | rkey_hit)
				remote_r <= 1'b1;
			else if (cmd_gtl | ex_m0 | lkey_hit)
				remote_r <= 1'b0;
			if (!ren_s)
				lockout_r <= 1'b0;
			else if (cmd_llo | ex_m2)
				lockout_r <= 1'b1;
			else if (ex_m0)
				lockout_r <= 1'b0;
		end
	end

	// ==================================================================
	// command buffer, written by index
	always_ff @(posedge clk) begin
		if (take_data && rx_data != CHAR_CR && rx_data != CHAR_LF && !wr_r[BUF_AW])
			buf_r[wr_r[BUF_AW-1:0]] <= rx_data;
	end

	// ==================================================================
	// sequencer: command replay and talker output
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r      <= ph_idle;
			wr_r         <= '0;
			rd_r         <= '0;
			got_cr_r     <= 1'b0;
			prev_r       <= 8'h00;
			req_r        <= REQ_RESET;
			sent_r       <= 1'b0;
			tx_valid_r   <= 1'b0;
			tx_data_r    <= 8'h00;
			tx_eoi_r     <= 1'b0;
			rec_ready_r  <= 1'b0;
			rec_req_r    <= 1'b0;
			last_r       <= 1'b0;
			exec_valid_r <= 1'b0;
			exec_char_r  <= 8'h00;
			exec_last_r  <= 1'b0;
		end else begin
			rec_req_r    <= 1'b0;
			exec_valid_r <= 1'b0;
			exec_last_r  <= 1'b0;
			if (!talker_r)
				sent_r <= 1'b0;                     // fresh talk turn next time
			if (do_clear) begin
				// a clear drops pending work and the output request
				phase_r     <= ph_idle;
				wr_r        <= '0;
				rd_r        <= '0;
				got_cr_r    <= 1'b0;
				req_r       <= REQ_RESET;
				tx_valid_r  <= 1'b0;
				rec_ready_r <= 1'b0;
			end else begin
				unique case (phase_r)
					ph_idle: begin
						if (take_data) begin
							if (rx_data == CHAR_LF && got_cr_r) begin
								phase_r  <= ph_exec;
								rd_r     <= '0;
								prev_r   <= 8'h00;
								got_cr_r <= 1'b0;
							end else if (rx_data == CHAR_CR) begin
								got_cr_r <= 1'b1;
							end else begin
								// stray LF or ordinary char; overflow is dropped
								got_cr_r <= 1'b0;
								if (rx_data != CHAR_LF && !wr_r[BUF_AW])
									wr_r <= wr_r + 1'b1;
							end
						end else if (talker_r && !sent_r) begin
							if (spoll_r) begin
								phase_r    <= ph_poll;
								tx_data_r  <= status_byte;
								tx_eoi_r   <= 1'b0;
								tx_valid_r <= 1'b1;
							end else begin
								phase_r     <= ph_rec;
								rec_req_r   <= 1'b1;
								rec_ready_r <= 1'b1;
							end
						end
					end
					ph_exec: begin
						if (rd_r == wr_r) begin
							phase_r <= ph_idle;
							wr_r    <= '0;
						end else begin
							exec_valid_r <= 1'b1;
							exec_char_r  <= cur_ch;
							exec_last_r  <= (rd_r + 1'b1 == wr_r);
							prev_r       <= cur_ch;
							rd_r         <= rd_r + 1'b1;
							if (ex_req)
								req_r <= cur_ch;
						end
					end
					ph_rec: begin
						if (!talker_r) begin
							phase_r     <= ph_idle;     // addressing withdrawn
							tx_valid_r  <= 1'b0;
							rec_ready_r <= 1'b0;
						end else if (tx_taken) begin
							tx_valid_r  <= 1'b0;
							rec_ready_r <= !last_r;
							if (last_r)
								phase_r <= ph_cr;
						end else if (rec_ready_r && rec_valid) begin
							tx_data_r   <= rec_data;
							tx_eoi_r    <= 1'b0;
							tx_valid_r  <= 1'b1;
							rec_ready_r <= 1'b0;
							last_r      <= rec_last;
						end
					end
					ph_cr, ph_lf: begin
						if (!talker_r) begin
							phase_r    <= ph_idle;
							tx_valid_r <= 1'b0;
						end else if (tx_taken) begin
							tx_valid_r <= 1'b0;
							if (phase_r == ph_lf) begin
								phase_r <= ph_idle;
								sent_r  <= 1'b1;
							end else
								phase_r <= ph_lf;
						end else if (!tx_valid_r) begin
							tx_data_r  <= (phase_r == ph_cr) ? CHAR_CR : CHAR_LF;
							tx_eoi_r   <= (phase_r == ph_lf);
							tx_valid_r <= 1'b1;
						end
					end
					ph_poll: begin
						if (tx_taken || !talker_r) begin
							phase_r    <= ph_idle;
							tx_valid_r <= 1'b0;
							sent_r     <= tx_taken;
						end
					end
					default: phase_r <= ph_idle;
				endcase
			end
		end
	end

	// ==================================================================
	// service request pin, clear pulse, address display
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			srq_oe_r <= 1'b0;
			srq_o_r  <= 1'b0;
			clear_r  <= 1'b0;
			show_r   <= 1'b0;
		end else begin
			srq_oe_r <= service_req;
			srq_o_r  <= 1'b0;                       // open drain only pulls low
			clear_r  <= do_clear;
			show_r   <= hold_s;
		end
	end

	// ==================================================================
	// outputs straight from flops, except rx_busy which is decoded from phase_r
	assign rx_busy     = (phase_r != ph_idle);
	assign tx_valid    = tx_valid_r;
	assign tx_data     = tx_data_r;
	assign tx_eoi      = tx_eoi_r;
	assign rec_req     = rec_req_r;
	assign out_request = req_r;
	assign rec_ready   = rec_ready_r;
	assign exec_valid  = exec_valid_r;
	assign exec_char   = exec_char_r;
	assign exec_last   = exec_last_r;
	assign dev_clear   = clear_r;
	assign srq_o       = srq_o_r;
	assign srq_oe      = srq_oe_r;
	assign remote      = remote_r;
	assign lockout     = lockout_r;
	assign listener    = listener_r;
	assign talker      = talker_r;
	assign show_addr   = show_r;
	assign disp_addr   = my_addr_r;

endmodule // gpib_device_message_handler

// ==== src/msg_pkg.sv ====
/*
 * constants, types and helpers shared by the bus message handler, its checker and its test.
 * assumes a single 250 MHz clock domain and a byte-wide acceptor/source handshake
 * built elsewhere on that same clock.
 */
// Operation
// - only REN and IFC act as uniline inputs
// - REN low plus own listen address: remote
// - raise SRQ to ask for service
// - act on LLO and DCL under ATN
// - LLO locks out front panel controls; code blocks only the local key, remote key still acts
// - DCL returns settings to power-up
// - addressed commands only when own listener
// - SDC clears like DCL when addressed
// - GTL while addressed leaves remote mode
// - after SPE, talker sends status byte; code acts on SPE only while own listener
// - UNL puts listener into idle
// - UNT puts talker into idle
// - ATN-high bytes are data, not messages
// - listen only in remote; M0/GTL give local
// - talking allowed while still in local
// - address switches sampled at power-up only
// - address maps to talk/listen characters
// - command strings only while listener addressed
// - buffer chars, execute after both terminators
// - last output request picks next record
// - remote key held over 1 s: show address
// - first switch bit weighs 16, last 1
// - records end CR LF, EOI with LF
// - handshake lines belong to outside logic
package msg_pkg;

	// ==================================================================
	// interface message codes (ATN asserted)
	localparam logic [7:0] CMD_GTL     = 8'h01;
	localparam logic [7:0] CMD_SDC     = 8'h04;
	localparam logic [7:0] CMD_LLO     = 8'h11;
	localparam logic [7:0] CMD_DCL     = 8'h14;
	localparam logic [7:0] CMD_SPE     = 8'h18;
	localparam logic [7:0] CMD_SPD     = 8'h19;
	localparam logic [7:0] CMD_UNL     = 8'h3f;
	localparam logic [7:0] CMD_UNT     = 8'h5f;
	localparam logic [1:0] GRP_LISTEN  = 2'h1;    // bits 6:5 of a listen address
	localparam logic [1:0] GRP_TALK    = 2'h2;    // bits 6:5 of a talk address

	// ==================================================================
	// data characters
	localparam logic [7:0] CHAR_CR     = 8'h0d;
	localparam logic [7:0] CHAR_LF     = 8'h0a;
	localparam logic [7:0] CHAR_MODE   = 8'h4d;   // 'M'
	localparam logic [7:0] CHAR_REQ    = 8'h57;   // 'W'
	localparam logic [7:0] CHAR_0      = 8'h30;
	localparam logic [7:0] CHAR_1      = 8'h31;
	localparam logic [7:0] CHAR_2      = 8'h32;

	// ==================================================================
	// sizes, positions, reset values
	localparam int         ADDR_W      = 5;
	localparam int         BUF_DEPTH   = 16;
	localparam int         BUF_AW      = 4;
	localparam int         STB_RQS     = 6;       // request-service bit in status byte
	localparam logic [1:0] BOOT_LAST   = 2'h3;    // last startup count; switches are caught at the count before
	localparam logic [7:0] REQ_RESET   = 8'h00;   // no output request yet

	// ==================================================================
	// timing
	localparam int         CLK_HZ          = 250000000;
	localparam int         KEY_HOLD_MS     = 1000;
	localparam int         KEY_HOLD_CYCLES = CLK_HZ / 1000 * KEY_HOLD_MS;

	// ==================================================================
	// sequencer phases
	typedef enum logic [2:0] {
		ph_idle,    // waiting for data or a talk turn
		ph_exec,    // replaying buffered command characters
		ph_rec,     // forwarding a data record
		ph_cr,      // first terminator
		ph_lf,      // second terminator with end flag
		ph_poll     // serial poll status byte
	} phase_e;

	// address character for a given group
	function automatic logic [7:0] addr_char(input logic [1:0] grp,
		input logic [ADDR_W-1:0] a);
		return {1'b0, grp, a};
	endfunction

endpackage

// ==== src/sync2.sv ====
/*
 * two-stage synchroniser for a group of independent level inputs.
 * assumes each bit is a slow level; multi-bit words are not kept coherent.
 */
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	// ==================================================================
	// one pair of flops per bit; first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_r;    // first stage, read by second only
			logic sync_r;    // settled copy
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else begin
					meta_r <= din[i];
					sync_r <= meta_r;
				end
			end
			assign dout[i] = sync_r;
		end
	endgenerate

endmodule // sync2

// ==== src/hold_timer.sv ====
/*
 * measures how long a key has been held and flags when it passes a limit.
 * assumes the key level is already synchronised and active high.
 */
`timescale 1ns/1ps
module hold_timer #(
	parameter int unsigned CYCLES = 1000
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic key,
	output logic      held
);

	localparam int CW = $clog2(CYCLES + 2);

	logic [CW-1:0] cnt_r;     // saturating hold count
	logic          held_r;    // limit passed

	wire  at_top = (cnt_r > CW'(CYCLES));    // strictly longer than the limit

	// ==================================================================
	// count while pressed, restart on release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r  <= '0;
			held_r <= 1'b0;
		end else begin
			if (!key)
				cnt_r <= '0;
			else if (!at_top)
				cnt_r <= cnt_r + 1'b1;
			held_r <= key & at_top;
		end
	end

	assign held = held_r;

endmodule // hold_timer

// ==== bench/handler_chk.sv ====
/* port checker for the bus message handler.
   assumes one clock domain; bound to the handler at the foot. */
`timescale 1ns/1ps
module handler_chk
	import msg_pkg::*;
(
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic              ren_n,
	input wire logic              ifc_n,
	input wire logic              rx_valid,
	input wire logic [7:0]        rx_data,
	input wire logic              rx_atn,
	input wire logic              tx_valid,
	input wire logic [7:0]        tx_data,
	input wire logic              tx_eoi,
	input wire logic              tx_ready,
	input wire logic              rec_req,
	input wire logic              dev_clear,
	input wire logic              remote,
	input wire logic              lockout,
	input wire logic              listener,
	input wire logic              talker,
	input wire logic [ADDR_W-1:0] disp_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ====================
	// interface byte taken this cycle; ff is no command we act on
	wire logic [7:0] cmd = (rx_valid && rx_atn) ? rx_data : 8'hff;
	sequence s_cr_taken;
		tx_valid && tx_ready && tx_data == CHAR_CR && !tx_eoi;
	endsequence
	a_dcl_clears: assert property (cmd == CMD_DCL |-> ##[1:2] dev_clear)
		else $error("no clear pulse after device clear");
	a_llo_locks: assert property (cmd == CMD_LLO && !ren_n && !$past(ren_n, 2) |=> lockout)
		else $error("lockout not set");
	a_unl_idle: assert property (cmd == CMD_UNL |=> !listener)
		else $error("listener kept after unlisten");
	a_unt_idle: assert property (cmd == CMD_UNT |=> !talker)
		else $error("talker kept after untalk");
	a_own_listen: assert property (cmd == {3'h1, disp_addr} |=> listener && !talker)
		else $error("own listen address missed");
	a_gtl_local: assert property (cmd == CMD_GTL && listener |=> !remote)
		else $error("still remote after go to local");
	a_sdc_skip: assert property (cmd == CMD_SDC && !listener |-> ##1 !dev_clear)
		else $error("clear while not addressed");
	a_ifc_idle: assert property (!ifc_n [*5] |-> !listener && !talker)
		else $error("addressing kept during interface clear");
	a_talk_turn: assert property (cmd == {3'h2, disp_addr} && !talker |-> ##[1:3] (rec_req || tx_valid))
		else $error("no talk turn after own talk address");
	a_lf_eoi: assert property (s_cr_taken |-> ##[1:2] (tx_valid && tx_data == CHAR_LF && tx_eoi))
		else $error("record not closed by LF with end flag");
endmodule // handler_chk

bind gpib_device_message_handler handler_chk chk (
	.clk, .reset_n, .ren_n, .ifc_n, .rx_valid, .rx_data, .rx_atn, .tx_valid, .tx_data,
	.tx_eoi, .tx_ready, .rec_req, .dev_clear, .remote, .lockout, .listener, .talker,
	.disp_addr
);

// ==== bench/ctrl_model.sv ====
/* bus controller model: sends interface messages and data bytes, takes talker bytes.
   assumes the acceptor and source handshakes sit on the same clock. */
`timescale 1ns/1ps
module ctrl_model (
	input wire logic        clk,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_atn,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_eoi,
	output logic            tx_ready
);
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_atn = 1'b0;
		tx_ready = 1'b0;
	end
	// atn high: interface message, low: device data
	task send(input logic atn, input logic [7:0] b);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		rx_atn <= atn;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b; // released lines must not keep the byte
	endtask
	// stall then take one talker byte
	task get(input int stall, output logic [7:0] b, output logic e);
		int i;
		repeat (stall + 1) @(posedge clk); // one edge between two takes
		tx_ready <= 1'b1;
		i = 0;
		do @(posedge clk); while (!(tx_valid === 1'b1 && tx_ready) && ++i < 200);
		b = tx_data;
		e = tx_eoi;
		tx_ready <= 1'b0;
	endtask
endmodule // ctrl_model

// ==== bench/gpib_device_message_handler_test.sv ====
/* self-checking bench for the bus message handler.
   assumes address switches at 12 from power-up and REN held asserted. */
`timescale 1ns/1ps
module gpib_device_message_handler_test
	import msg_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic ren_n = 1'b0;
	logic ifc_n = 1'b1;
	logic remote_key = 1'b0;
	logic rec_valid = 1'b0;
	logic rec_last = 1'b0;
	logic service_req = 1'b0;
	logic [7:0] rec_data = 8'h00;
	logic [7:0] status_in = 8'h05;
	logic [ADDR_W-1:0] addr_sw = 5'h0c;
	logic [ADDR_W-1:0] disp_addr;
	logic [7:0] rx_data, tx_data, out_request, d;
	logic rx_valid, rx_atn, tx_ready, rx_busy, tx_valid, tx_eoi, rec_req, rec_ready, e;
	logic dev_clear, exec_valid, srq_o, srq_oe, remote, lockout, listener, talker, show_addr;
	logic exec_last, local_key = 1'b0;
	logic [7:0] exec_char, last_ch = 8'h00;
	int n_fail = 0;
	int n_checks = 0;
	int n_exec = 0;
	int n_clr = 0;
	int n_rreq = 0;
	gpib_device_message_handler #(.KEY_HOLD(20)) dut (
		.clk, .reset_n, .ren_n, .ifc_n, .addr_sw, .local_key, .remote_key,
		.rx_valid, .rx_data, .rx_atn, .rx_busy, .tx_valid, .tx_data, .tx_eoi,
		.tx_ready, .rec_req, .out_request, .rec_ready, .rec_valid, .rec_data,
		.rec_last, .exec_valid, .exec_char, .exec_last, .dev_clear,
		.service_req, .status_in, .srq_o, .srq_oe, .remote, .lockout,
		.listener, .talker, .show_addr, .disp_addr
	);
	ctrl_model ctl (.clk, .rx_valid, .rx_data, .rx_atn, .tx_valid, .tx_data, .tx_eoi, .tx_ready);
	initial forever #2 clk = ~clk;
	// ====================
	// pulse counters, so short pulses are never missed
	always @(posedge clk) begin
		if (exec_valid === 1'b1) n_exec++;
		if (dev_clear === 1'b1) n_clr++;
		if (rec_req === 1'b1) n_rreq++;
		if (exec_last === 1'b1) last_ch = exec_char;
	end
	task chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cmd(input logic [7:0] c);
		ctl.send(1'b1, c);
		#1;
	endtask
	// data string with CR LF, then wait out the replay
	task say(input string s);
		int i;
		foreach (s[k]) ctl.send(1'b0, s[k]);
		ctl.send(1'b0, CHAR_CR);
		ctl.send(1'b0, CHAR_LF);
		i = 0;
		do @(posedge clk); while (rx_busy !== 1'b0 && ++i < 60);
		#1;
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// whole run is under two hundred cycles
	initial begin
		#80000;
		n_fail++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		addr_sw <= 5'h03; // late change must not move the address
		#1;
		chk(disp_addr, 9'h00c);
		cmd(8'h2c); // comma: listen 12
		chk({listener, remote}, 9'h003);
		cmd(CMD_LLO);
		chk(lockout, 9'h001);
		@(posedge clk);
		local_key <= 1'b1; // locked panel key must not give local
		repeat (4) @(posedge clk);
		local_key <= 1'b0;
		#1;
		chk(remote, 9'h001);
		cmd(CMD_GTL);
		chk(remote, 9'h000);
		say("W1");
		chk(9'(n_exec), 9'h000);
		cmd(8'h2c);
		say("W1M0");
		chk(9'(n_exec), 9'h004);
		chk(out_request, CHAR_1);
		chk(last_ch, CHAR_0);
		chk(remote, 9'h000);
		cmd(CMD_DCL);
		@(posedge clk);
		#1;
		chk(9'(n_clr), 9'h001);
		chk(out_request, 9'h000);
		cmd(CMD_SDC);
		@(posedge clk);
		#1;
		chk(9'(n_clr), 9'h002);
		cmd(8'h2c); // listen again, remote comes back
		cmd(CMD_UNL);
		chk({listener, remote}, 9'h001);
		cmd(CMD_SDC);
		say("W2");
		chk(9'(n_clr), 9'h002);
		chk(9'(n_exec), 9'h004);
		cmd(8'h2c);
		say("M0"); // back to local before talking
		cmd(8'h4c); // L: talk 12, still local
		chk({talker, remote}, 9'h002);
		@(posedge clk);
		rec_valid <= 1'b1;
		rec_data <= 8'h41;
		rec_last <= 1'b1;
		do @(posedge clk); while (!(rec_ready === 1'b1 && rec_valid) && $time < 60000);
		rec_valid <= 1'b0;
		rec_data <= 8'hbe;
		rec_last <= 1'b0;
		ctl.get(0, d, e);
		chk({e, d}, 9'h041);
		ctl.get(3, d, e); // controller slow to take CR
		chk({e, d}, 9'h00d);
		ctl.get(0, d, e);
		chk({e, d}, 9'h10a);
		chk(9'(n_rreq), 9'h001);
		cmd(CMD_UNT);
		chk(talker, 9'h000);
		chk(disp_addr, 9'h00c);
		@(posedge clk);
		service_req <= 1'b1;
		cmd(8'h2c);
		chk({srq_oe, srq_o}, 9'h002);
		cmd(CMD_SPE);
		cmd(8'h4c);
		ctl.get(2, d, e);
		chk({e, d}, 9'h045);
		cmd(CMD_SPD);
		@(posedge clk);
		ifc_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk({listener, talker}, 9'h000);
		@(posedge clk);
		ifc_n <= 1'b1;
		remote_key <= 1'b1;
		repeat (30) @(posedge clk);
		#1;
		chk(show_addr, 9'h001);
		@(posedge clk);
		remote_key <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk(show_addr, 9'h000);
		complete_run();
	end
endmodule // gpib_device_message_handler_test
